/* rtl/scd_top.sv */
// Two-channel sinc3 decimator feeding a burst or frame-synchronized serial port.
`timescale 1ns/1ps
module scd_top #(
    parameter int MOD_HALF = scd_pkg::MOD_HALF_CYC,
    parameter int SER_HALF = scd_pkg::SER_HALF_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic port_mode_sw,
    input wire logic [2:0] ratio_sw,
    input wire logic [1:0] mod_mode_sw,
    input wire logic modulator_clock_in,
    input wire logic [scd_pkg::CHANNELS-1:0] modulator_bitstream,
    output logic modulator_clock_out,
    output logic spi_sclk,
    output logic spi_ss_n,
    output logic frame_port_receive_clock,
    output logic receive_frame_pulse_line,
    output logic filter_result_out
);
    import scd_pkg::*;

    // Scales a differentiator output of 3k+1 bits to a full 16-bit word, saturating at full scale.
    function automatic logic [WORD_W-1:0] scale(input logic [ACC_W-1:0] v, input logic [3:0] k);
        logic [4:0] sh;
        logic [ACC_W-1:0] t;
        sh = SCALE_TOP - 5'(k * 3);
        t = v << sh;
        return t[ACC_W-1] ? SAT_VALUE : t[ACC_W-2:ACC_W-1-WORD_W];
    endfunction : scale

    // Two-stage synchronizers for every strap and modulator pin input.
    logic [8:0] meta_q, sync_q;
    logic mclk_prev_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
            mclk_prev_q <= 1'b0;
        end else begin
            meta_q <= {port_mode_sw, ratio_sw, mod_mode_sw, modulator_clock_in, modulator_bitstream};
            sync_q <= meta_q;
            mclk_prev_q <= sync_q[2];
        end
    end

    // Strap decoding; closed switches read as 0, so the code is the pin level.
    wire spi_mode = !sync_q[8];
    wire [2:0] code = sync_q[7:5];
    wire [1:0] mod_mode = sync_q[4:3];
    wire mclk_s = sync_q[2];
    wire [CHANNELS-1:0] dat_s = sync_q[1:0];
    wire [3:0] log2r = (code == CODE_UNDEF) ? LOG2_MAX : 4'({1'b0, code}) + LOG2_OFFSET;
    wire [CNT_W-1:0] dec_last = CNT_W'((9'h001 << log2r) - 9'h001);

    // Modulator clock divider, driven out only in the external-clock mode.
    logic [3:0] mdiv_q;
    logic mclk_int_q, mclk_out_q;
    wire mdiv_end = (mdiv_q == 4'(MOD_HALF - 1));
    wire int_rise = mdiv_end && !mclk_int_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mdiv_q <= '0;
            mclk_int_q <= 1'b0;
            mclk_out_q <= 1'b0;
        end else begin
            mdiv_q <= mdiv_end ? 4'h0 : mdiv_q + 4'h1;
            mclk_int_q <= mclk_int_q ^ mdiv_end;
            mclk_out_q <= (mod_mode == MOD_EXT) && (mclk_int_q ^ mdiv_end);
        end
    end

    // Bit capture per modulator mode.
    wire ext_rise = mclk_s && !mclk_prev_q;
    wire ext_fall = !mclk_s && mclk_prev_q;
    logic [CHANNELS-1:0] half_q;
    wire bit_ok = (mod_mode == MOD_RISE) ? ext_rise :
                  (mod_mode == MOD_BOTH) ? (ext_rise || ext_fall) :
                  (mod_mode == MOD_MANCH) ? ext_fall : int_rise;
    wire [CHANNELS-1:0] bit_v = (mod_mode == MOD_MANCH) ? half_q : dat_s;

    // Sinc3 integrators at the bit rate and differentiators at the decimated rate.
    logic [ACC_W-1:0] i1_q [CHANNELS], i2_q [CHANNELS], i3_q [CHANNELS];
    logic [ACC_W-1:0] z1_q [CHANNELS], z2_q [CHANNELS], z3_q [CHANNELS];
    logic [ACC_W-1:0] d1 [CHANNELS], d2 [CHANNELS], d3 [CHANNELS];
    logic [CNT_W-1:0] dec_cnt_q;
    wire dec_ev = bit_ok && (dec_cnt_q >= dec_last);
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            d1[c] = i3_q[c] - z1_q[c];
            d2[c] = d1[c] - z2_q[c];
            d3[c] = d2[c] - z3_q[c];
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dec_cnt_q <= '0;
            half_q <= '0;
            for (int c = 0; c < CHANNELS; c++) begin
                i1_q[c] <= '0;
                i2_q[c] <= '0;
                i3_q[c] <= '0;
                z1_q[c] <= '0;
                z2_q[c] <= '0;
                z3_q[c] <= '0;
            end
        end else begin
            if (ext_rise) begin
                half_q <= dat_s;
            end
            if (bit_ok) begin
                dec_cnt_q <= dec_ev ? '0 : dec_cnt_q + 8'h01;
                for (int c = 0; c < CHANNELS; c++) begin
                    i1_q[c] <= i1_q[c] + ACC_W'(bit_v[c]);
                    i2_q[c] <= i2_q[c] + i1_q[c];
                    i3_q[c] <= i3_q[c] + i2_q[c];
                end
            end
            if (dec_ev) begin
                for (int c = 0; c < CHANNELS; c++) begin
                    z1_q[c] <= i3_q[c];
                    z2_q[c] <= d1[c];
                    z3_q[c] <= d2[c];
                end
            end
        end
    end

    // Result collection: two channels per output, four outputs per bank, banks alternate.
    logic ch1_pend_q, wbank_q, sbank_q, ready_q, bank_done_q;
    logic [1:0] slot_q;
    logic [WORD_W-1:0] res1_q;
    wire wr_en = dec_ev || ch1_pend_q;
    wire [MEM_AW-1:0] wr_addr = {wbank_q, slot_q, ch1_pend_q};
    wire [WORD_W-1:0] wr_data = ch1_pend_q ? res1_q : scale(d3[0], log2r);
    wire bank_done = ch1_pend_q && (slot_q == LAST_SLOT);

    // Serializer state.
    scd_state_e state_q, state_d;
    logic [1:0] scnt_q;
    logic ph_q;
    logic [3:0] bit_q;
    logic [2:0] word_q;
    logic [WORD_W-1:0] sh_q;
    logic sdo_q, sclk_q, ss_n_q, fclk_q, fpulse_q;
    logic [WORD_W-1:0] rd_data;
    wire tick = (scnt_q == 2'(SER_HALF - 1));
    wire fall = tick && ph_q;
    wire ph_d = ph_q ^ tick;
    wire start = fall && ready_q && (state_q == SCD_IDLE);
    wire last = fall && (state_q == SCD_SHIFT) && (bit_q == LAST_BIT) && (word_q == LAST_WORD);
    wire [2:0] rd_word = (state_q == SCD_IDLE) ? 3'h0 : word_q + 3'h1;
    wire [MEM_AW-1:0] rd_addr = {sbank_q, rd_word};
    always_comb begin
        state_d = state_q;
        if (start) begin
            state_d = SCD_SHIFT;
        end else if (last) begin
            state_d = SCD_IDLE;
        end
    end

    // Bank bookkeeping; a completed bank sets the ready flag, which wins over the start clear.
    // The flag is set one cycle after the bank swap, so the registered read port already shows the new first word.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ch1_pend_q <= 1'b0;
            res1_q <= '0;
            slot_q <= '0;
            wbank_q <= 1'b0;
            sbank_q <= 1'b0;
            ready_q <= 1'b0;
            bank_done_q <= 1'b0;
        end else begin
            ch1_pend_q <= dec_ev;
            if (dec_ev) begin
                res1_q <= scale(d3[1], log2r);
            end
            if (ch1_pend_q) begin
                slot_q <= slot_q + 2'h1;
            end
            if (bank_done) begin
                wbank_q <= !wbank_q;
                sbank_q <= wbank_q;
            end
            bank_done_q <= bank_done;
            ready_q <= bank_done_q || (ready_q && !start);
        end
    end

    scd_mem #(.WIDTH(WORD_W), .AW(MEM_AW), .DEPTH(MEM_DEPTH)) u_mem (
        .clock(clock),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data_q(rd_data)
    );

    // Serial timing base and shifter; data changes on the falling serial edge, MSB first.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            scnt_q <= '0;
            ph_q <= 1'b0;
            state_q <= SCD_IDLE;
            bit_q <= '0;
            word_q <= '0;
            sh_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            scnt_q <= tick ? 2'h0 : scnt_q + 2'h1;
            ph_q <= ph_d;
            state_q <= state_d;
            if (start) begin
                bit_q <= '0;
                word_q <= '0;
                sdo_q <= rd_data[WORD_W-1];
                sh_q <= {rd_data[WORD_W-2:0], 1'b0};
            end else if (last) begin
                sdo_q <= 1'b0;
            end else if (fall && state_q == SCD_SHIFT) begin
                bit_q <= bit_q + 4'h1;
                if (bit_q == LAST_BIT) begin
                    word_q <= word_q + 3'h1;
                    sdo_q <= rd_data[WORD_W-1];
                    sh_q <= {rd_data[WORD_W-2:0], 1'b0};
                end else begin
                    sdo_q <= sh_q[WORD_W-1];
                    sh_q <= {sh_q[WORD_W-2:0], 1'b0};
                end
            end
        end
    end

    // Port pins: burst clock and select in one mode, free clock and frame pulse in the other.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
            ss_n_q <= 1'b1;
            fclk_q <= 1'b0;
            fpulse_q <= 1'b0;
        end else begin
            sclk_q <= spi_mode && (state_d == SCD_SHIFT) && ph_d;
            ss_n_q <= !(spi_mode && (state_d == SCD_SHIFT));
            fclk_q <= !spi_mode && ph_d;
            fpulse_q <= (start && !spi_mode) || (fpulse_q && !fall);
        end
    end

    assign modulator_clock_out = mclk_out_q;
    assign spi_sclk = sclk_q;
    assign spi_ss_n = ss_n_q;
    assign frame_port_receive_clock = fclk_q;
    assign receive_frame_pulse_line = fpulse_q;
    assign filter_result_out = sdo_q;

    // Checks on the port and filter behaviour.
    localparam int SER_GAP = 3;
    localparam int MOD_GAP = 5;
    sequence s_start_fp;
        start && !spi_mode;
    endsequence
    sequence s_first_bit;
        fpulse_q && (state_q == SCD_SHIFT) && (bit_q == 4'h0) && (word_q == 3'h0);
    endsequence
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_select_frame_idle: assert property ($past(!spi_mode) |-> ss_n_q)
        else $error("Select asserted in frame mode.");
    chk_fclk_spi_idle: assert property ($past(spi_mode) |-> !fclk_q)
        else $error("Frame clock running in burst mode.");
    chk_sclk_cpol_zero: assert property (ss_n_q |-> !sclk_q)
        else $error("Burst clock not idle low.");
    chk_fclk_free_run: assert property ((!spi_mode && fclk_q) |-> ##[1:SER_GAP] (!fclk_q || spi_mode))
        else $error("Frame clock stopped.");
    chk_frame_first_bit: assert property (s_start_fp |=> s_first_bit)
        else $error("Frame pulse not aligned to first bit.");
    chk_burst_eight_words: assert property ($fell(state_q == SCD_SHIFT) |-> $past(word_q) == LAST_WORD)
        else $error("Burst did not carry eight words.");
    chk_sdo_from_mem: assert property (start |=> sdo_q == $past(rd_data[WORD_W-1]))
        else $error("Serial data not taken from result memory.");
    chk_ratio_code_zero: assert property ((code == 3'h0) |-> dec_last == 8'h03)
        else $error("Code zero does not give ratio four.");
    chk_undef_code_max: assert property ((code == CODE_UNDEF) |-> dec_last == 8'hFF)
        else $error("Undefined code not treated as ratio 256.");
    chk_mclk_ext_only: assert property ((mod_mode != MOD_EXT) |=> !mclk_out_q)
        else $error("Modulator clock driven outside external mode.");
    chk_mclk_toggles: assert property ((mod_mode == MOD_EXT && mclk_out_q) |-> ##[1:MOD_GAP] (!mclk_out_q || mod_mode != MOD_EXT))
        else $error("Modulator clock not toggling.");
    chk_dec_window: assert property (dec_ev |=> dec_cnt_q == 8'h00)
        else $error("Decimation counter not restarted.");
endmodule : scd_top

/* inc/scd_pkg.sv */
// Shared constants and types for the third-order sinc decimator with host serial output.
package scd_pkg;
    // Clock rate and timing figures.
    localparam int SYS_CLK_MHZ = 10;
    localparam int MOD_HALF_NS = 400;
    localparam int MOD_HALF_CYC = (MOD_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SER_HALF_NS = 200;
    localparam int SER_HALF_CYC = (SER_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
    // Data path widths and burst layout.
    localparam int WORD_W = 16;
    localparam int ACC_W = 25;
    localparam int CHANNELS = 2;
    localparam int BURST_WORDS = 8;
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam int CNT_W = 8;
    // Decimation code decoding: ratio is two to the power of (code plus offset), or of LOG2_MAX for CODE_UNDEF.
    localparam logic [2:0] CODE_UNDEF = 3'h7;
    localparam logic [3:0] LOG2_OFFSET = 4'h2;
    localparam logic [3:0] LOG2_MAX = 4'h8;
    localparam logic [4:0] SCALE_TOP = 5'h18;
    localparam logic [WORD_W-1:0] SAT_VALUE = 16'hFFFF;
    // Modulator clock-configuration modes.
    localparam logic [1:0] MOD_RISE = 2'h0;
    localparam logic [1:0] MOD_BOTH = 2'h1;
    localparam logic [1:0] MOD_MANCH = 2'h2;
    localparam logic [1:0] MOD_EXT = 2'h3;
    // Serializer and bank-slot counters.
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam logic [2:0] LAST_WORD = 3'h7;
    localparam logic [1:0] LAST_SLOT = 2'h3;
    typedef enum logic {SCD_IDLE, SCD_SHIFT} scd_state_e;
endpackage : scd_pkg

/* rtl/scd_mem.sv */
// Small result memory with one write port and a registered read port.
`timescale 1ns/1ps
module scd_mem #(
    parameter int WIDTH = 16,
    parameter int AW = 4,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_q
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // Store on write, and present the addressed word one cycle later.
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data_q <= mem_q[rd_addr];
    end
endmodule : scd_mem

/* tb/scd_host_model.sv */
// Host serial receiver model that collects result words in either port mode.
`timescale 1ns/1ps
module scd_host_model (
    input wire logic nrst,
    input wire logic port_mode_sw,
    input wire logic spi_sclk,
    input wire logic spi_ss_n,
    input wire logic frame_port_receive_clock,
    input wire logic receive_frame_pulse_line,
    input wire logic filter_result_out
);
    logic [15:0] words [0:7];
    logic [15:0] sh_q = 16'h0000;
    int nbits = 1000;
    int bursts = 0;
    longint prev_t = 0;
    longint last_t = 0;
    // Shifts one bit in MSB first and files each whole word of a burst.
    task automatic take(input logic d);
        sh_q = {sh_q[14:0], d};
        nbits++;
        if (nbits % 16 == 0 && nbits <= 128) begin
            words[nbits / 16 - 1] = sh_q;
        end
        if (nbits == 128) begin
            bursts++;
        end
    endtask : take
    // Starts a new burst and keeps the start times of the last two.
    task automatic open_burst();
        nbits = 0;
        prev_t = last_t;
        last_t = $time;
    endtask : open_burst
    // A board reset drops any burst that was cut short.
    always @(negedge nrst) begin
        nbits = 1000;
    end
    // Slave with idle-low clock that samples on the rising edge while selected.
    always @(negedge spi_ss_n) begin
        if (!port_mode_sw) begin
            open_burst();
        end
    end
    always @(posedge spi_sclk) begin
        if (!port_mode_sw && !spi_ss_n) begin
            take(filter_result_out);
        end
    end
    // Active-high frame pulse; its first bit is taken at the same edge.
    always @(posedge frame_port_receive_clock) begin
        if (port_mode_sw) begin
            if (receive_frame_pulse_line) begin
                open_burst();
            end
            take(filter_result_out);
        end
    end
endmodule : scd_host_model

/* tb/test_scd_top.sv */
// Self-checking bench for the sinc3 decimator and its host serial port.
`timescale 1ns/1ps
module test_scd_top;
    import scd_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic port_mode_sw = 1'b1;
    logic [2:0] ratio_sw = 3'h0;
    logic [1:0] mod_mode_sw = 2'h3;
    logic modulator_clock_in = 1'b0;
    logic half_q = 1'b0;
    logic [1:0] mod_div = 2'h0;
    logic [1:0] lvl = 2'h0;
    logic man_en = 1'b0;
    logic rnd_en = 1'b0;
    logic mclk_run = 1'b0;
    logic mon_en = 1'b0;
    logic fr_prev = 1'b0;
    logic mc_prev = 1'b0;
    logic [CHANNELS-1:0] modulator_bitstream;
    logic modulator_clock_out, spi_sclk, spi_ss_n;
    logic frame_port_receive_clock, receive_frame_pulse_line, filter_result_out;
    int fail_count = 0;
    int n_tests = 0;
    int fr_same = 0;
    int mc_same = 0;
    always #50 clock = ~clock;
    // Modulator clock for modes 0 to 2, 800 ns period; the data phase leads it by a quarter period.
    always @(posedge clock) begin
        mod_div <= mod_div + 2'h1;
        if (mod_div == 2'h1) begin
            half_q <= ~modulator_clock_in;
        end
        if (mod_div == 2'h3) begin
            modulator_clock_in <= mclk_run & ~modulator_clock_in;
        end
    end
    // Manchester sends the bit in the high half and its inverse in the low half.
    assign modulator_bitstream = lvl ^ {2{man_en & ~half_q}};
    always @(posedge clock) begin
        if (rnd_en) begin
            lvl <= 2'($urandom);
        end
    end
    scd_top u_scd_top (.clock(clock), .nrst(nrst), .port_mode_sw(port_mode_sw), .ratio_sw(ratio_sw),
        .mod_mode_sw(mod_mode_sw), .modulator_clock_in(modulator_clock_in),
        .modulator_bitstream(modulator_bitstream), .modulator_clock_out(modulator_clock_out),
        .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .frame_port_receive_clock(frame_port_receive_clock),
        .receive_frame_pulse_line(receive_frame_pulse_line), .filter_result_out(filter_result_out));
    scd_host_model u_scd_host_model (.nrst(nrst), .port_mode_sw(port_mode_sw), .spi_sclk(spi_sclk),
        .spi_ss_n(spi_ss_n), .frame_port_receive_clock(frame_port_receive_clock),
        .receive_frame_pulse_line(receive_frame_pulse_line), .filter_result_out(filter_result_out));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // Words alternate channel 0 and channel 1; constant input gives full scale or zero.
    function automatic logic [15:0] exp_word(input int k, input logic [1:0] lv);
        return lv[k % 2] ? 16'hFFFF : 16'h0000;
    endfunction : exp_word
    // System cycles per bank of four outputs: code 7 acts as ratio 256, mode 1 takes two bits a period.
    function automatic int bank_cycles(input logic [2:0] code, input logic [1:0] mm);
        return 4 * (1 << (code == 3'h7 ? 8 : code + 2)) * (mm == MOD_BOTH ? 4 : 8);
    endfunction : bank_cycles
    // Unused port lines stay idle (select high, the rest low), the frame and modulator clocks keep running when used; sampled on the falling edge.
    always @(negedge clock) begin
        fr_same = (frame_port_receive_clock === fr_prev) ? fr_same + 1 : 0;
        mc_same = (modulator_clock_out === mc_prev) ? mc_same + 1 : 0;
        fr_prev = frame_port_receive_clock;
        mc_prev = modulator_clock_out;
        if (mon_en) begin
            if (port_mode_sw) begin
                chk(spi_ss_n === 1'b1 && spi_sclk === 1'b0, "burst lines active in frame mode");
                chk(fr_same < 2, "frame clock not running");
            end else begin
                chk(frame_port_receive_clock === 1'b0 && receive_frame_pulse_line === 1'b0, "frame lines active");
                chk(spi_ss_n === 1'b0 || spi_sclk === 1'b0, "burst clock without select");
            end
            chk(mod_mode_sw == MOD_EXT ? mc_same < 4 : modulator_clock_out === 1'b0, "modulator clock");
        end
    end
    // One case: reset with new straps, then judge the third burst.
    task automatic run_case(input logic pm, input logic [2:0] code, input logic [1:0] mm, input logic [1:0] lv,
                            input logic rnd);
        int b0;
        int per;
        @(posedge clock);
        mon_en <= 1'b0;
        nrst <= 1'b0;
        port_mode_sw <= pm;
        ratio_sw <= code;
        mod_mode_sw <= mm;
        lvl <= lv;
        rnd_en <= rnd;
        man_en <= (mm == MOD_MANCH);
        mclk_run <= (mm != MOD_EXT);
        repeat (5) @(posedge clock);
        chk({modulator_clock_out, spi_sclk, spi_ss_n, frame_port_receive_clock, receive_frame_pulse_line,
             filter_result_out} === 6'h08, "reset values");
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        mon_en <= 1'b1;
        b0 = u_scd_host_model.bursts;
        for (int i = 0; i < 40000 && u_scd_host_model.bursts < b0 + 3; i++) begin
            @(posedge clock);
        end
        chk(u_scd_host_model.bursts >= b0 + 3, "bursts missing");
        for (int k = 0; k < 8 && !rnd; k++) begin
            chk(u_scd_host_model.words[k] === exp_word(k, lv), "result word");
        end
        per = bank_cycles(code, mm) * 100;
        if (per > 52000) begin
            chk(u_scd_host_model.last_t - u_scd_host_model.prev_t inside {[per - 400 : per + 400]}, "spacing");
        end
        $display("case done: port %0d code %0d modulator mode %0d", pm, code, mm);
    endtask : run_case
    // Corner cases per mode, random straps and levels, then code 7 with random data.
    initial begin
        void'($urandom(96));
        run_case(1'b0, 3'h0, MOD_EXT, 2'h1, 1'b0);
        run_case(1'b1, 3'h1, MOD_RISE, 2'h2, 1'b0);
        run_case(1'b1, 3'h2, MOD_BOTH, 2'h1, 1'b0);
        run_case(1'b0, 3'h5, MOD_MANCH, 2'h2, 1'b0);
        run_case(1'b0, 3'h6, MOD_BOTH, 2'h3, 1'b0);
        for (int i = 0; i < 3; i++) begin
            run_case(1'($urandom), 3'($urandom % 5), 2'($urandom), 2'($urandom), 1'b0);
        end
        run_case(1'b1, 3'h7, MOD_EXT, 2'h0, 1'b1);
        conclude();
    end
    // Cuts a hang short well after the expected run length.
    initial begin
        #9000000;
        fail_count++;
        $display("[ERR] %0t run did not complete", $time);
        conclude();
    end
endmodule : test_scd_top
